// *** verilog/power_mode_controller.v ***
// Idle and power-down mode controller with its power configuration register
//
// Overview of operation
// - Idle stops CPU clock, peripherals keep clocking
// - Idle holds PC, PSW, SFRs and RAM
// - Idle starts when the setting instruction completes
// - Both bits set means power-down only
// - Enabled interrupt ends Idle, clears idle bit
// - Reset pin clears idle bit, then resets core
// - Block RAM, allow ports before reset takes over
// - Power-down halts oscillator and every clock
// - Power-down preserves PC, PSW, SFRs, RAM
// - Power-down starts when setting instruction completes
// - Only enabled external interrupts wake power-down
// - Wake clears powerdown bit, restarts oscillator, clocks
// - Execution waits until wake pin released
// - Interrupt wake leaves SFRs and RAM untouched
// - Two general flags only software changes
// - Powerdown bit 1, idle bit 0, hardware-cleared
// - Reset pin ends power-down and restarts clocks
`timescale 1ns/1ns
`default_nettype none
`include "power_mode_regs.vh"

module power_mode_controller #(
  parameter [7:0] OSC_STARTUP_CYCLES = `OSC_STARTUP_CYC,
  parameter [7:0] RST_TAKEOVER_CYCLES = `RST_TAKEOVER_CYC
) (
  // Clock and reset
  input wire mclk_in,
  input wire reset_in,
  // Register port
  input wire [`ADDR_WIDTH-1:0] addr_in,
  input wire [`DATA_WIDTH-1:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [`DATA_WIDTH-1:0] rdata_out,
  // CPU core
  input wire instr_done_in,
  output reg cpu_clk_en_out,
  output reg exec_hold_out,
  output reg state_hold_out,
  output reg ram_block_out,
  output reg core_reset_out,
  output reg [15:0] reset_vector_out,
  // Interrupt controller
  input wire irq_pending_in,
  input wire int_zero_en_in,
  input wire int_one_en_in,
  // Clock tree
  output reg periph_clk_en_out,
  output reg osc_enable_out,
  // External pins
  input wire ext_interrupt_zero_n_in,
  input wire ext_interrupt_one_n_in,
  input wire external_reset_input_in
);

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_PDOWN = 3'h2;
  localparam [2:0] ST_WAKE = 3'h3;
  localparam [2:0] ST_HOLD = 3'h4;
  localparam [2:0] ST_RSTWIN = 3'h5;
  localparam [2:0] ST_CORERST = 3'h6;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] cnt_reg;
  reg [7:0] cnt_next;
  reg idle_request_bit_reg;
  reg idle_request_bit_next;
  reg powerdown_request_bit_reg;
  reg powerdown_request_bit_next;
  reg general_flag_zero_reg;
  reg general_flag_zero_next;
  reg general_flag_one_reg;
  reg general_flag_one_next;
  reg [`DATA_WIDTH-1:0] rd_mux;
  wire wake;
  wire cfg_write;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function hits;
    input [`ADDR_WIDTH-1:0] addr;
    input [`ADDR_WIDTH-1:0] target;
    begin
      hits = (addr == target);
    end
  endfunction

  function cpu_clocked;
    input [2:0] st;
    begin
      cpu_clocked = (st == ST_RUN) || (st == ST_HOLD) ||
                    (st == ST_RSTWIN) || (st == ST_CORERST);
    end
  endfunction

  // ---------------------------------------------------------------
  // Wake path
  // ---------------------------------------------------------------
  wake_detect wake_detect_inst (
    .ext_interrupt_zero_n_in(ext_interrupt_zero_n_in),
    .ext_interrupt_one_n_in(ext_interrupt_one_n_in),
    .int_zero_en_in(int_zero_en_in),
    .int_one_en_in(int_one_en_in),
    .wake_out(wake)
  );

  assign cfg_write = wr_in && hits(addr_in, `PWR_CONFIG_ADDR);

  // ---------------------------------------------------------------
  // Configuration bits, software side
  // ---------------------------------------------------------------
  always @* begin
    idle_request_bit_next = idle_request_bit_reg;
    powerdown_request_bit_next = powerdown_request_bit_reg;
    general_flag_zero_next = general_flag_zero_reg;
    general_flag_one_next = general_flag_one_reg;
    if (cfg_write) begin
      idle_request_bit_next = wdata_in[`IDLE_REQ_BIT];
      powerdown_request_bit_next = wdata_in[`PDOWN_REQ_BIT];
      // Only reset_in clears the flags; no other hardware event touches them
      general_flag_zero_next = wdata_in[`GFLAG_ZERO_BIT];
      general_flag_one_next = wdata_in[`GFLAG_ONE_BIT];
    end
    // Hardware clears below override the software view
    if (external_reset_input_in) begin
      idle_request_bit_next = 1'b0;
      powerdown_request_bit_next = 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (irq_pending_in) begin
            idle_request_bit_next = 1'b0;
          end
        end
        ST_PDOWN: begin
          if (wake) begin
            // Idle bit also drops so the exit does not fall into Idle
            powerdown_request_bit_next = 1'b0;
            idle_request_bit_next = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (external_reset_input_in &&
        (state_reg != ST_RSTWIN) && (state_reg != ST_CORERST)) begin
      // Clocks return at once; the core reset follows later
      state_next = ST_RSTWIN;
      cnt_next = 8'h00;
    end else begin
      case (state_reg)
        ST_RUN: begin
          if (instr_done_in && powerdown_request_bit_next) begin
            state_next = ST_PDOWN;
          end else if (instr_done_in && idle_request_bit_next) begin
            state_next = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (irq_pending_in) begin
            state_next = ST_RUN;
          end
        end
        ST_PDOWN: begin
          // Other interrupt sources are ignored here
          if (wake) begin
            state_next = ST_WAKE;
            cnt_next = 8'h00;
          end
        end
        ST_WAKE: begin
          // Startup runs its full count whether or not the pin stays asserted
          if (cnt_reg >= OSC_STARTUP_CYCLES - 8'h01) begin
            state_next = ST_HOLD;
          end else begin
            cnt_next = cnt_reg + 8'h01;
          end
        end
        ST_HOLD: begin
          if (!wake) begin
            state_next = ST_RUN;
          end
        end
        ST_RSTWIN: begin
          if (cnt_reg >= RST_TAKEOVER_CYCLES - 8'h01) begin
            state_next = ST_CORERST;
          end else begin
            cnt_next = cnt_reg + 8'h01;
          end
        end
        ST_CORERST: begin
          if (!external_reset_input_in) begin
            state_next = ST_RUN;
          end
        end
        default: begin
          state_next = ST_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read multiplexer
  // ---------------------------------------------------------------
  always @* begin
    rd_mux = {`DATA_WIDTH{1'b0}};
    if (hits(addr_in, `PWR_CONFIG_ADDR)) begin
      rd_mux[`IDLE_REQ_BIT] = idle_request_bit_reg;
      rd_mux[`PDOWN_REQ_BIT] = powerdown_request_bit_reg;
      rd_mux[`GFLAG_ZERO_BIT] = general_flag_zero_reg;
      rd_mux[`GFLAG_ONE_BIT] = general_flag_one_reg;
    end else if (hits(addr_in, `PWR_STATUS_ADDR)) begin
      rd_mux[`STAT_IDLE_BIT] = (state_reg == ST_IDLE);
      rd_mux[`STAT_PDOWN_BIT] = (state_reg == ST_PDOWN);
      rd_mux[`STAT_WAKE_BIT] = (state_reg == ST_WAKE);
      rd_mux[`STAT_HOLD_BIT] = (state_reg == ST_HOLD);
      rd_mux[`STAT_RSTWIN_BIT] = (state_reg == ST_RSTWIN);
      rd_mux[`STAT_CORERST_BIT] = (state_reg == ST_CORERST);
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (reset_in) begin
      state_reg <= ST_RUN;
      cnt_reg <= 8'h00;
      idle_request_bit_reg <= 1'b0;
      powerdown_request_bit_reg <= 1'b0;
      general_flag_zero_reg <= 1'b0;
      general_flag_one_reg <= 1'b0;
      rdata_out <= {`DATA_WIDTH{1'b0}};
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      idle_request_bit_reg <= idle_request_bit_next;
      powerdown_request_bit_reg <= powerdown_request_bit_next;
      general_flag_zero_reg <= general_flag_zero_next;
      general_flag_one_reg <= general_flag_one_next;
      // Data stand only in the cycle after the read strobe
      rdata_out <= rd_in ? rd_mux : {`DATA_WIDTH{1'b0}};
    end
  end

  // ---------------------------------------------------------------
  // Clock and core controls, registered from the next state
  // ---------------------------------------------------------------
  // Driving from state_next lets the gate close on the completing edge
  always @(posedge mclk_in) begin
    if (reset_in) begin
      cpu_clk_en_out <= 1'b1;
      periph_clk_en_out <= 1'b1;
      osc_enable_out <= 1'b1;
      exec_hold_out <= 1'b0;
      state_hold_out <= 1'b0;
      ram_block_out <= 1'b0;
      core_reset_out <= 1'b0;
      reset_vector_out <= `RESET_VECTOR;
    end else begin
      cpu_clk_en_out <= cpu_clocked(state_next);
      // Peripherals stay clocked in Idle, stop in power-down
      periph_clk_en_out <= (state_next != ST_PDOWN) &&
                           (state_next != ST_WAKE);
      osc_enable_out <= (state_next != ST_PDOWN);
      exec_hold_out <= (state_next == ST_HOLD) ||
                       (state_next == ST_WAKE);
      // Freeze keeps PC, PSW, SFR and RAM contents as they were
      state_hold_out <= (state_next == ST_IDLE) || (state_next == ST_PDOWN) ||
                        (state_next == ST_WAKE) || (state_next == ST_HOLD);
      // Ports stay reachable; only the internal RAM is fenced off
      ram_block_out <= (state_next == ST_RSTWIN);
      core_reset_out <= (state_next == ST_CORERST);
      reset_vector_out <= `RESET_VECTOR;
    end
  end

endmodule // power_mode_controller

`default_nettype wire

// *** verilog/power_mode_regs.vh ***
// Register offsets, field positions, reset values and timing counts of the power-mode controller
`ifndef POWER_MODE_REGS_VH
`define POWER_MODE_REGS_VH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define ADDR_WIDTH 8
`define DATA_WIDTH 8
`define PWR_CONFIG_ADDR 8'h87
`define PWR_STATUS_ADDR 8'h88

// ---------------------------------------------------------------
// Power config register fields
// ---------------------------------------------------------------
`define IDLE_REQ_BIT 0
`define PDOWN_REQ_BIT 1
`define GFLAG_ZERO_BIT 2
`define GFLAG_ONE_BIT 3
`define PWR_CONFIG_RESET 4'h0

// ---------------------------------------------------------------
// Power status register fields
// ---------------------------------------------------------------
`define STAT_IDLE_BIT 0
`define STAT_PDOWN_BIT 1
`define STAT_WAKE_BIT 2
`define STAT_HOLD_BIT 3
`define STAT_RSTWIN_BIT 4
`define STAT_CORERST_BIT 5

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define OSC_STARTUP_NS 2000
`define RST_TAKEOVER_NS 400
// Counts sized to the 8-bit counter; nanosecond figures above at one clock period each
`define OSC_STARTUP_CYC 8'h14
`define RST_TAKEOVER_CYC 8'h04
`define RESET_VECTOR 16'h0000

`endif

// *** verilog/wake_detect.v ***
// Clockless level detector for the external wake pins
`timescale 1ns/1ns
`default_nettype none

module wake_detect (
  // External pins, active low
  input wire ext_interrupt_zero_n_in,
  input wire ext_interrupt_one_n_in,
  // Enables from the interrupt controller
  input wire int_zero_en_in,
  input wire int_one_en_in,
  // Detection result
  output wire wake_out
);

  // ---------------------------------------------------------------
  // Level detect
  // ---------------------------------------------------------------
  // No clock runs in power-down, so only gates sit on this path
  assign wake_out = (~ext_interrupt_zero_n_in & int_zero_en_in) |
                    (~ext_interrupt_one_n_in & int_one_en_in);

endmodule // wake_detect

`default_nettype wire

// *** verification/power_mode_controller_properties.sv ***
// Port-level assertions for the power-mode controller
`timescale 1ns/1ns
`default_nettype none
module power_mode_checker #(
  parameter [7:0] OSC_STARTUP_CYCLES = 8'h14,
  parameter [7:0] RST_TAKEOVER_CYCLES = 8'h04
) (
  // Clock, reset, bus and core
  input wire logic mclk_in, reset_in, wr_in, instr_done_in, irq_pending_in,
  input wire logic [7:0] addr_in, wdata_in,
  // Mode outputs
  input wire logic cpu_clk_en_out, exec_hold_out, state_hold_out, ram_block_out,
  input wire logic core_reset_out, periph_clk_en_out, osc_enable_out,
  input wire logic [15:0] reset_vector_out,
  // Pins and enables
  input wire logic int_zero_en_in, int_one_en_in, external_reset_input_in,
  input wire logic ext_interrupt_zero_n_in, ext_interrupt_one_n_in
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  wire run = cpu_clk_en_out && !state_hold_out && !exec_hold_out && !ram_block_out;
  wire quiet = !external_reset_input_in;
  wire cfg_wr = wr_in && instr_done_in && addr_in == 8'h87 && quiet && !core_reset_out;
  wire woke = (!ext_interrupt_zero_n_in && int_zero_en_in) ||
    (!ext_interrupt_one_n_in && int_one_en_in);
  wire pins_up = ext_interrupt_zero_n_in && ext_interrupt_one_n_in;
  a_idle_entry:
  assert property (run && cfg_wr && wdata_in[1:0] == 2'b01 |=> !cpu_clk_en_out &&
    periph_clk_en_out && osc_enable_out && state_hold_out) else $error("idle entry wrong");
  a_pdown_entry:
  assert property (run && cfg_wr && wdata_in[1] |=> !cpu_clk_en_out && !periph_clk_en_out &&
    !osc_enable_out) else $error("power-down entry wrong");
  a_idle_irq_exit:
  assert property (!cpu_clk_en_out && periph_clk_en_out && osc_enable_out && irq_pending_in
    && quiet |=> cpu_clk_en_out && !state_hold_out) else $error("idle exit wrong");
  a_pdown_wake:
  assert property (!osc_enable_out && woke && quiet |=> osc_enable_out && exec_hold_out &&
    !cpu_clk_en_out) else $error("wake from power-down wrong");
  a_pdown_stays:
  assert property (!osc_enable_out && !woke && quiet |=> !osc_enable_out && state_hold_out)
    else $error("power-down left without cause");
  a_startup_len:
  assert property ($rose(cpu_clk_en_out) && exec_hold_out |-> periph_clk_en_out &&
    $past(osc_enable_out, OSC_STARTUP_CYCLES) &&
    !$past(osc_enable_out, OSC_STARTUP_CYCLES + 8'h01)) else $error("startup length wrong");
  a_hold_while_low:
  assert property (exec_hold_out && cpu_clk_en_out && woke && quiet |=> exec_hold_out &&
    state_hold_out) else $error("execution resumed with pin low");
  a_hold_release:
  assert property (exec_hold_out && cpu_clk_en_out && pins_up && quiet |=> !exec_hold_out
    && !state_hold_out && cpu_clk_en_out) else $error("hold not released");
  a_reset_pin:
  assert property (!quiet && !ram_block_out && !core_reset_out |=> ram_block_out &&
    cpu_clk_en_out && osc_enable_out && !exec_hold_out) else $error("reset pin exit wrong");
  a_takeover_len:
  assert property ($rose(core_reset_out) |-> !ram_block_out &&
    $past(ram_block_out, RST_TAKEOVER_CYCLES) &&
    !$past(ram_block_out, RST_TAKEOVER_CYCLES + 8'h01)) else $error("takeover length wrong");
  a_vector_zero:
  assert property (core_reset_out |-> reset_vector_out == 16'h0000) else $error("bad vector");
endmodule // power_mode_checker

bind power_mode_controller power_mode_checker #(.OSC_STARTUP_CYCLES(OSC_STARTUP_CYCLES),
  .RST_TAKEOVER_CYCLES(RST_TAKEOVER_CYCLES)) u_checker (.mclk_in, .reset_in, .wr_in,
  .instr_done_in, .irq_pending_in, .addr_in, .wdata_in, .cpu_clk_en_out, .exec_hold_out,
  .state_hold_out, .ram_block_out, .core_reset_out, .periph_clk_en_out, .osc_enable_out,
  .reset_vector_out, .int_zero_en_in, .int_one_en_in, .external_reset_input_in,
  .ext_interrupt_zero_n_in, .ext_interrupt_one_n_in);
`default_nettype wire

// *** verification/far_side_model.sv ***
// CPU core and wake pin model on the far side of the controller
`timescale 1ns/1ns
`default_nettype none
module far_side_model (
  input wire logic mclk_in,
  input wire logic cpu_clk_en_in,
  input wire logic exec_hold_in,
  input wire logic ram_block_in,
  output wire logic instr_done_out,
  output var logic pin0_n_out,
  output var logic pin1_n_out
);
  // One instruction retires in every cycle the core is clocked and free
  assign instr_done_out = cpu_clk_en_in && !exec_hold_in && !ram_block_in;
  initial begin
    pin0_n_out = 1'b1;
    pin1_n_out = 1'b1;
  end
  // Level wake source; pulled up again once released
  task automatic hold_low(input integer sel, input integer len);
    @(posedge mclk_in);
    if (sel == 0) pin0_n_out <= 1'b0;
    else pin1_n_out <= 1'b0;
    repeat (len) @(posedge mclk_in);
    pin0_n_out <= 1'b1;
    pin1_n_out <= 1'b1;
  endtask
endmodule // far_side_model
`default_nettype wire

// *** verification/test_power_mode_controller.sv ***
// Self-checking bench for the power-mode controller
`timescale 1ns/1ns
`default_nettype none
`include "power_mode_regs.vh"
module test_power_mode_controller;
  logic mclk_in, reset_in, wr_in, rd_in, irq_pending_in, external_reset_input_in;
  logic [7:0] addr_in, wdata_in, rdata_out, flags;
  logic [1:0] int_en;
  logic [15:0] reset_vector_out;
  wire instr_done_in, pin0_n, pin1_n, cpu_clk_en_out, exec_hold_out, state_hold_out;
  wire ram_block_out, core_reset_out, periph_clk_en_out, osc_enable_out;
  wire [7:0] outs = {1'b0, osc_enable_out, periph_clk_en_out, cpu_clk_en_out,
    exec_hold_out, state_hold_out, ram_block_out, core_reset_out};
  integer n_mismatch = 0, samples_checked = 0, seed = 32'h2E69, i, p;

  // Short counts keep wake and takeover quick
  power_mode_controller #(.OSC_STARTUP_CYCLES(8'h03), .RST_TAKEOVER_CYCLES(8'h02)) u_dut (
    .mclk_in(mclk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .instr_done_in(instr_done_in),
    .cpu_clk_en_out(cpu_clk_en_out), .exec_hold_out(exec_hold_out),
    .state_hold_out(state_hold_out), .ram_block_out(ram_block_out),
    .core_reset_out(core_reset_out), .reset_vector_out(reset_vector_out),
    .irq_pending_in(irq_pending_in), .int_zero_en_in(int_en[0]), .int_one_en_in(int_en[1]),
    .periph_clk_en_out(periph_clk_en_out), .osc_enable_out(osc_enable_out),
    .ext_interrupt_zero_n_in(pin0_n), .ext_interrupt_one_n_in(pin1_n),
    .external_reset_input_in(external_reset_input_in));
  far_side_model u_far (.mclk_in(mclk_in), .cpu_clk_en_in(cpu_clk_en_out),
    .exec_hold_in(exec_hold_out), .ram_block_in(ram_block_out),
    .instr_done_out(instr_done_in), .pin0_n_out(pin0_n), .pin1_n_out(pin1_n));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  function automatic logic [7:0] mode_outs(input logic [1:0] m);
    mode_outs = m[1] ? 8'h04 : (m[0] ? 8'h64 : 8'h70);
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input integer n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 chk(what, rdata_out, exp);
  endtask
  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and scenarios
  // ---------------------------------------------------------------
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  initial begin
    #(5000 * 100);
    n_mismatch++;
    results;
  end
  initial begin
    reset_in = 1'b1;
    {wr_in, rd_in, irq_pending_in, external_reset_input_in} = 4'h0;
    {addr_in, wdata_in, int_en} = 18'h00000;
    repeat (8) @(posedge mclk_in);
    reset_in <= 1'b0;
    tick(1);
    chk("outs", outs, mode_outs(2'b00));
    rd(`PWR_CONFIG_ADDR, 8'h00, "config");
    for (i = 0; i < 8; i++) begin
      flags = 8'($random(seed)) & 8'h0C;
      wr(`PWR_CONFIG_ADDR, flags);
      wr(8'h90 + 8'(i), 8'hFF);
      rd(8'h90 + 8'(i), 8'h00, "unmapped");
      rd(`PWR_CONFIG_ADDR, flags, "flags");
    end
    wr(`PWR_CONFIG_ADDR, flags | 8'h01);
    tick(1);
    chk("outs", outs, mode_outs(2'b01));
    rd(`PWR_CONFIG_ADDR, flags | 8'h01, "config");
    rd(`PWR_STATUS_ADDR, 8'h01, "status");
    @(posedge mclk_in) irq_pending_in <= 1'b1;
    @(posedge mclk_in) irq_pending_in <= 1'b0;
    #1 chk("outs", outs, mode_outs(2'b00));
    rd(`PWR_CONFIG_ADDR, flags, "config");
    for (p = 0; p < 2; p++) begin
      int_en <= 2'b00;
      wr(`PWR_CONFIG_ADDR, 8'h03);
      tick(1);
      chk("outs", outs, mode_outs(2'b11));
      rd(`PWR_STATUS_ADDR, 8'h02, "status");
      @(posedge mclk_in) irq_pending_in <= 1'b1;
      @(posedge mclk_in) irq_pending_in <= 1'b0;
      fork u_far.hold_low(p, 2); join_none
      tick(4);
      chk("outs", outs, 8'h04);
      int_en[p] <= 1'b1;
      fork u_far.hold_low(p, 10); join_none
      tick(2);
      chk("outs", outs, 8'h4C);
      rd(`PWR_CONFIG_ADDR, 8'h00, "config");
      tick(4);
      chk("outs", outs, 8'h7C);
      tick(5);
      chk("outs", outs, mode_outs(2'b00));
    end
    for (p = 1; p < 3; p++) begin
      wr(`PWR_CONFIG_ADDR, flags | 8'(p));
      tick(1);
      @(posedge mclk_in) external_reset_input_in <= 1'b1;
      tick(1);
      chk("window", outs, 8'h72);
      // Status read spans the two window cycles before takeover
      rd(`PWR_STATUS_ADDR, 8'h10, "status");
      chk("takeover", outs, 8'h71);
      chk("vector", reset_vector_out[15:8] | reset_vector_out[7:0], 8'h00);
      @(posedge mclk_in) external_reset_input_in <= 1'b0;
      tick(2);
      chk("outs", outs, mode_outs(2'b00));
      rd(`PWR_CONFIG_ADDR, flags, "config");
    end
    results;
  end
endmodule // test_power_mode_controller
`default_nettype wire
